// file: core/harvester_pkg.sv
// harvester_pkg: constants and carrier types for the serial command port
// assumes one 20 MHz clock and a 9600 baud 8N1 serial link to a host
// Summary of operation
// - link runs 9600 baud, eight data bits, no parity, one stop bit
// - reply: at sign, command digit, comma, data, CR, LF, ASCII zero
// - numeric fields are fixed-width decimal, left padded with zeros
// - command 1 returns available power in microwatts, five digits
// - enter storage charging after capacitor charging, regulation when regulating
// - capacitor charging keeps the output capacitor off the load
// - command 3 returns the two-digit transducer code
// - command 4 restarts tracking, replies ACK, cuts harvester from load
// - tracking runs unasked only at start or regulation loss with input change
// - command 5 returns charge percentage, three digits; host asks twice
// - command 6 captures output reading as reference and returns four digits
// - active-low calibrate input also starts the capture
// - command 7 returns power, state, transducer and charge concatenated
// - command 8 returns the fixed value 99
// - command 9 measures input power up to ten seconds, replies ACK
// - reduced build drops commands 1, 2, 3 and 9
// - three active-low indicators; during tracking they also shunt excess energy
// - in regulation with storage charged all three indicators pulse together
package harvester_pkg;
  // clock and link timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam int unsigned MEASURE_S = 10;
  localparam int unsigned MEASURE_CYC_DEF = MEASURE_S * CLK_HZ;
  localparam int unsigned BLINK_PERIOD_MS = 1000;
  localparam int unsigned BLINK_LOW_MS = 50;
  localparam int unsigned BLINK_PERIOD_CYC_DEF = BLINK_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_LOW_CYC_DEF = BLINK_LOW_MS * (CLK_HZ / 1000);
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned MSG_MAX = 18;
  localparam int unsigned FLD_MAX = 12;
  // protocol characters
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_ACK = 8'h06;
  // reset values
  localparam logic [2:0] IND_OFF_N = 3'h7;
  // operating state and parser state, one-hot
  typedef enum logic [4:0] {
    PM_TRACK = 5'h01,
    PM_CAP = 5'h02,
    PM_STORE = 5'h04,
    PM_REG = 5'h08,
    PM_OFF = 5'h10
  } pm_state_t;
  typedef enum logic [3:0] {
    PS_HASH = 4'h1,
    PS_SPACE = 4'h2,
    PS_DIGIT = 4'h4,
    PS_CR = 4'h8
  } parse_state_t;
  localparam pm_state_t PM_RESET = PM_TRACK;
  localparam parse_state_t PS_RESET = PS_HASH;
  // readings from the converter front end
  typedef struct packed {
    logic [16:0] power_uw;
    logic [6:0] charge_pct;
    logic [13:0] vout_adc;
  } meas_t;
  // plant status levels
  typedef struct packed {
    logic in_regulation;
    logic cap_charged;
    logic storage_full;
    logic vin_changed;
    logic tracking_done;
    logic measure_done;
    logic output_off;
    logic excess_energy;
  } plant_t;
  // power path commands
  typedef struct packed {
    logic tracking_start;
    logic measure_start;
    logic cal_capture;
    logic load_off;
    logic harvester_on;
  } ctrl_t;
endpackage

// file: core/byte_fifo.sv
// byte_fifo: small synchronous FIFO with valid/ready on both sides
// assumes one clock; full stalls the writer, empty holds the reader
`timescale 1ns/1ns
`default_nettype none
module byte_fifo
  import harvester_pkg::*;
#(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // write side
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // read side
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;
  fifo_st_t q;
  fifo_st_t d;
  logic push;
  logic pop;

  // honest flags straight from the count
  assign in_ready_o = q.cnt != (AW+1)'(D);
  assign out_valid_o = q.cnt != '0;
  assign out_data_o = q.mem[q.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointer wrap works because D is a power of two
  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = in_data_i;
      d.wp = q.wp + 1'b1;
    end
    if (pop)
      d.rp = q.rp + 1'b1;
    if (push && !pop)
      d.cnt = q.cnt + 1'b1;
    else if (pop && !push)
      d.cnt = q.cnt - 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q <= '0;
    else
      q <= d;
  end
endmodule
`default_nettype wire

// file: core/uart_8n1.sv
// uart_8n1: serial receiver and transmitter, fixed 8N1 framing
// assumes rxd_i already synchronous to clk_i and idle high
`timescale 1ns/1ns
`default_nettype none
module uart_8n1
  import harvester_pkg::*;
#(
  parameter int unsigned BIT_CYC_P = BIT_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // serial pins
  input wire logic rxd_i,
  output logic txd_o,
  // received bytes
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  // bytes to send
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  // bit period stays at 9600 baud unless a bench shortens it
  localparam logic [11:0] BIT_LAST = 12'(BIT_CYC_P - 1);
  localparam logic [11:0] BIT_HALF = 12'(BIT_CYC_P / 2);
  typedef struct packed {
    logic rx_busy;
    logic [11:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic rx_valid;
    logic tx_busy;
    logic [11:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic txd;
  } uart_st_t;
  uart_st_t q;
  uart_st_t d;

  assign txd_o = q.txd;
  assign rx_data_o = q.rx_data;
  assign rx_valid_o = q.rx_valid;
  assign tx_ready_o = !q.tx_busy;

  // mid-bit sampling, a false start drops back to idle
  always_comb
  begin
    d = q;
    d.rx_valid = 1'b0;
    if (!q.rx_busy)
    begin
      if (!rxd_i)
      begin
        d.rx_busy = 1'b1;
        d.rx_cnt = BIT_HALF;
        d.rx_bit = '0;
      end
    end
    else if (q.rx_cnt != '0)
      d.rx_cnt = q.rx_cnt - 1'b1;
    else
    begin
      d.rx_cnt = BIT_LAST;
      d.rx_bit = q.rx_bit + 1'b1;
      if (q.rx_bit == 4'h0)
        d.rx_busy = !rxd_i;
      else if (q.rx_bit <= 4'h8)
        d.rx_sh = {rxd_i, q.rx_sh[7:1]};
      else
      begin
        d.rx_busy = 1'b0;
        d.rx_valid = rxd_i; // bad stop bit drops the byte
        d.rx_data = q.rx_sh;
      end
    end
    // start, eight data bits lsb first, one stop bit
    if (!q.tx_busy)
    begin
      if (tx_valid_i)
      begin
        d.tx_busy = 1'b1;
        d.tx_sh = {1'b1, tx_data_i, 1'b0};
        d.txd = 1'b0;
        d.tx_bit = '0;
        d.tx_cnt = BIT_LAST;
      end
    end
    else if (q.tx_cnt != '0)
      d.tx_cnt = q.tx_cnt - 1'b1;
    else if (q.tx_bit == 4'h9)
      d.tx_busy = 1'b0;
    else
    begin
      d.tx_sh = {1'b1, q.tx_sh[9:1]};
      d.txd = q.tx_sh[1];
      d.tx_bit = q.tx_bit + 1'b1;
      d.tx_cnt = BIT_LAST;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q <= '{txd: 1'b1, default: '0};
    else
      q <= d;
  end
endmodule
`default_nettype wire

// file: core/harvester_serial_command_port.sv
// harvester_serial_command_port: request parser, reply builder, power state
// assumes host keeps the request format; readings and plant status are synchronous
`timescale 1ns/1ns
`default_nettype none
module harvester_serial_command_port
  import harvester_pkg::*;
#(
  parameter bit REDUCED_BUILD = 1'b0,
  parameter int unsigned MEASURE_CYC = MEASURE_CYC_DEF,
  parameter int unsigned BLINK_PERIOD_CYC = BLINK_PERIOD_CYC_DEF,
  parameter int unsigned BLINK_LOW_CYC = BLINK_LOW_CYC_DEF,
  parameter int unsigned BIT_CYC_P = BIT_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // serial link
  input wire logic rxd_i,
  output logic txd_o,
  // front end readings and straps
  input wire meas_t meas_i,
  input wire logic [1:0] mode_sel_i,
  input wire plant_t plant_i,
  input wire logic calibrate_n_i,
  // power path control
  output ctrl_t ctrl_o,
  output logic [13:0] cal_ref_o,
  // status indicators
  output logic storage_charging_indicator_n_o,
  output logic capacitor_charging_indicator_n_o,
  output logic power_tracking_indicator_n_o
);
  typedef struct packed {
    pm_state_t pm;
    parse_state_t ps;
    logic [3:0] cmd;
    logic init_done;
    logic busy;
    logic [4:0] idx;
    logic [4:0] len;
    logic [MSG_MAX-1:0][7:0] msg;
    logic measuring;
    logic [31:0] meas_cnt;
    logic [31:0] blink;
    logic cal_n_prev;
    logic [13:0] cal_ref;
    ctrl_t ctrl;
    logic [2:0] ind_n;
  } port_st_t;

  port_st_t q;
  port_st_t d;
  logic [7:0] rx_data;
  logic rx_valid;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic fifo_ready;

  // ==========================================================
  // helpers
  // one decimal digit of v, weight 10**k, as ASCII
  function automatic logic [7:0] dig(input logic [31:0] v, input int k);
    logic [31:0] p;
    p = 32'h0000_0001;
    for (int i = 0; i < k; i++)
      p = p * 32'h0000_000A;
    return CH_ZERO + 8'((v / p) % 32'h0000_000A);
  endfunction

  // reported state number
  function automatic logic [31:0] state_code(input pm_state_t s);
    case (s)
      PM_TRACK: state_code = 32'h0000_0001;
      PM_CAP: state_code = 32'h0000_0002;
      PM_STORE: state_code = 32'h0000_0003;
      PM_REG: state_code = 32'h0000_0004;
      PM_OFF: state_code = 32'h0000_0005;
      default: state_code = 32'h0000_0001;
    endcase
  endfunction

  // strap code to transducer number
  function automatic logic [31:0] xdcr_code(input logic [1:0] m);
    case (m)
      2'h0: xdcr_code = 32'h0000_0004;
      2'h1: xdcr_code = 32'h0000_0001;
      2'h2: xdcr_code = 32'h0000_0003;
      2'h3: xdcr_code = 32'h0000_0002;
      default: xdcr_code = 32'h0000_0001;
    endcase
  endfunction

  // ==========================================================
  // link and reply buffer
  uart_8n1 #(
    .BIT_CYC_P(BIT_CYC_P)
  ) u_uart (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .rxd_i(rxd_i),
    .txd_o(txd_o),
    .rx_data_o(rx_data),
    .rx_valid_o(rx_valid),
    .tx_data_i(tx_data),
    .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready)
  );

  // the transmitter drains it; when full the reply sequencer waits
  byte_fifo #(
    .W(8),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(q.msg[q.idx]),
    .in_valid_i(q.busy),
    .in_ready_o(fifo_ready),
    .out_data_o(tx_data),
    .out_valid_o(tx_valid),
    .out_ready_i(tx_ready)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    logic exec;
    logic digit_ok;
    logic cmd_ok;
    logic track_req;
    logic cal_edge;
    logic blink_lo;
    logic [2:0] lo;
    logic [FLD_MAX-1:0][7:0] fld;
    logic [4:0] flen;
    logic [MSG_MAX-1:0][7:0] m;
    parse_state_t resync;
    exec = 1'b0;
    track_req = 1'b0;
    cal_edge = 1'b0;
    blink_lo = 1'b0;
    fld = '0;
    flen = '0;
    m = '0;
    lo = '0;
    d = q;
    d.ctrl.tracking_start = 1'b0;
    d.ctrl.measure_start = 1'b0;
    d.ctrl.cal_capture = 1'b0;
    digit_ok = rx_data >= CH_ONE && rx_data <= CH_NINE;
    cmd_ok = !(REDUCED_BUILD && (rx_data[3:0] == 4'h1 || rx_data[3:0] == 4'h2
             || rx_data[3:0] == 4'h3 || rx_data[3:0] == 4'h9));
    resync = (rx_data == CH_HASH) ? PS_SPACE : PS_HASH;

    // request parser; any stray byte restarts the hunt for a hash
    if (rx_valid)
    begin
      case (q.ps)
        PS_HASH:
          d.ps = resync;
        PS_SPACE:
          d.ps = (rx_data == CH_SPACE) ? PS_DIGIT : resync;
        PS_DIGIT:
        begin
          d.ps = (digit_ok && cmd_ok) ? PS_CR : resync;
          d.cmd = rx_data[3:0];
        end
        PS_CR:
        begin
          d.ps = resync;
          exec = (rx_data == CH_CR) && !q.busy;
        end
        default:
          d.ps = PS_HASH;
      endcase
    end

    // data field per command
    case (q.cmd)
      4'h1:
      begin
        for (int j = 0; j < 5; j++)
          fld[j] = dig(32'(meas_i.power_uw), 4 - j);
        flen = 5'h05;
      end
      4'h2:
      begin
        fld[0] = dig(state_code(q.pm), 1);
        fld[1] = dig(state_code(q.pm), 0);
        flen = 5'h02;
      end
      4'h3:
      begin
        fld[0] = dig(xdcr_code(mode_sel_i), 1);
        fld[1] = dig(xdcr_code(mode_sel_i), 0);
        flen = 5'h02;
      end
      4'h4, 4'h9:
      begin
        fld[0] = CH_ACK;
        flen = 5'h01;
      end
      4'h5:
      begin
        for (int j = 0; j < 3; j++)
          fld[j] = dig(32'(meas_i.charge_pct), 2 - j);
        flen = 5'h03;
      end
      4'h6:
      begin
        for (int j = 0; j < 4; j++)
          fld[j] = dig(32'(meas_i.vout_adc), 3 - j);
        flen = 5'h04;
      end
      4'h7:
      begin
        for (int j = 0; j < 5; j++)
          fld[j] = dig(32'(meas_i.power_uw), 4 - j);
        fld[5] = dig(state_code(q.pm), 1);
        fld[6] = dig(state_code(q.pm), 0);
        fld[7] = dig(xdcr_code(mode_sel_i), 1);
        fld[8] = dig(xdcr_code(mode_sel_i), 0);
        for (int j = 0; j < 3; j++)
          fld[9 + j] = dig(32'(meas_i.charge_pct), 2 - j);
        flen = 5'h0C;
      end
      4'h8:
      begin
        fld[0] = CH_NINE;
        fld[1] = CH_NINE;
        flen = 5'h02;
      end
      default:
        flen = '0;
    endcase

    // frame around the field
    m[0] = CH_AT;
    m[1] = CH_ZERO + {4'h0, q.cmd};
    m[2] = CH_COMMA;
    for (int i = 0; i < FLD_MAX; i++)
      if (5'(i) < flen)
        m[3 + i] = fld[i];
    m[5'h03 + flen] = CH_CR;
    m[5'h04 + flen] = CH_LF;
    m[5'h05 + flen] = CH_ZERO;

    // reply sequencer; stalls while the buffer is full
    if (exec)
    begin
      d.busy = 1'b1;
      d.idx = '0;
      d.msg = m;
      d.len = flen + 5'h06;
    end
    else if (q.busy && fifo_ready)
    begin
      if (q.idx == q.len - 5'h01)
        d.busy = 1'b0;
      else
        d.idx = q.idx + 5'h01;
    end

    // operating state
    case (q.pm)
      PM_TRACK:
        if (plant_i.tracking_done)
          d.pm = !plant_i.cap_charged ? PM_CAP :
                 plant_i.in_regulation ? PM_REG : PM_STORE;
      PM_CAP:
        if (plant_i.cap_charged)
          d.pm = plant_i.in_regulation ? PM_REG : PM_STORE;
      PM_STORE:
        if (plant_i.in_regulation)
          d.pm = PM_REG;
      PM_REG:
        if (!plant_i.in_regulation && !plant_i.vin_changed)
          d.pm = PM_STORE;
      PM_OFF:
        if (!plant_i.output_off)
          d.pm = PM_STORE;
      default:
        d.pm = PM_RESET;
    endcase
    if (plant_i.output_off && q.pm != PM_TRACK)
      d.pm = PM_OFF;
    track_req = !q.init_done || (exec && q.cmd == 4'h4)
      || (q.pm == PM_REG && !plant_i.in_regulation && plant_i.vin_changed);
    if (track_req)
    begin
      d.pm = PM_TRACK;
      d.ctrl.tracking_start = 1'b1;
    end
    d.init_done = 1'b1;
    d.ctrl.load_off = d.pm == PM_CAP || d.pm == PM_OFF;
    d.ctrl.harvester_on = d.pm != PM_TRACK;

    // power measurement; the operating state is left untouched
    if (exec && q.cmd == 4'h9 && !q.measuring)
    begin
      d.measuring = 1'b1;
      d.meas_cnt = '0;
      d.ctrl.measure_start = 1'b1;
    end
    else if (q.measuring)
    begin
      if (plant_i.measure_done || q.meas_cnt == MEASURE_CYC - 1)
        d.measuring = 1'b0;
      else
        d.meas_cnt = q.meas_cnt + 32'h0000_0001;
    end

    // calibration from either source
    cal_edge = q.cal_n_prev && !calibrate_n_i;
    d.cal_n_prev = calibrate_n_i;
    if (cal_edge || (exec && q.cmd == 4'h6))
    begin
      d.cal_ref = meas_i.vout_adc;
      d.ctrl.cal_capture = 1'b1;
    end

    // indicators: one blink timer shared so joint pulses line up
    d.blink = (q.blink >= BLINK_PERIOD_CYC - 1) ? '0 : q.blink + 32'h0000_0001;
    blink_lo = q.blink < BLINK_LOW_CYC;
    case (d.pm)
      PM_TRACK:
        lo = plant_i.excess_energy ? 3'h7 : {2'h0, blink_lo};
      PM_CAP:
        lo = {1'b0, blink_lo, 1'b0};
      PM_STORE:
        lo = {blink_lo, 2'h0};
      PM_REG:
        lo = plant_i.storage_full ? {3{blink_lo}} : {blink_lo, 2'h0};
      PM_OFF:
        lo = {blink_lo, blink_lo, 1'b0};
      default:
        lo = '0;
    endcase
    d.ind_n = ~lo;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q <= '{pm: PM_RESET, ps: PS_RESET, ind_n: IND_OFF_N, cal_n_prev: 1'b1, default: '0};
    else
      q <= d;
  end

  // outputs straight from flops
  assign ctrl_o = q.ctrl;
  assign cal_ref_o = q.cal_ref;
  assign storage_charging_indicator_n_o = q.ind_n[2];
  assign capacitor_charging_indicator_n_o = q.ind_n[1];
  assign power_tracking_indicator_n_o = q.ind_n[0];
endmodule
`default_nettype wire

// file: test/harvester_port_sva.sv
// harvester_port_sva: port-level checks for the serial command port
// assumes binding onto the top module; one clock, async active-low reset
`timescale 1ns/1ns
`default_nettype none
module harvester_port_sva
  import harvester_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // inputs watched
  input wire meas_t meas_i,
  input wire plant_t plant_i,
  input wire logic calibrate_n_i,
  // outputs watched
  input wire ctrl_t ctrl_o,
  input wire logic [13:0] cal_ref_o,
  input wire logic storage_charging_indicator_n_o,
  input wire logic capacitor_charging_indicator_n_o,
  input wire logic power_tracking_indicator_n_o
);
  // ==========================================
  // all checks share one clock and reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_init_track: assert property (rst_n_i && !$past(rst_n_i) |=> ctrl_o.tracking_start)
    else $error("no tracking pulse after reset release");
  a_track_single: assert property (ctrl_o.tracking_start |=> !ctrl_o.tracking_start)
    else $error("tracking start longer than one cycle");
  a_harvest_cut: assert property (ctrl_o.tracking_start |-> ##[0:1] !ctrl_o.harvester_on)
    else $error("harvester still feeding load during tracking");
  a_cal_follow: assert property (ctrl_o.cal_capture |-> ##[0:1] cal_ref_o == meas_i.vout_adc)
    else $error("calibration reference not taken from reading");
  a_cal_pin: assert property ($fell(calibrate_n_i) |-> ##[1:3] ctrl_o.cal_capture)
    else $error("calibrate pin did not start capture");
  a_measure_single: assert property (ctrl_o.measure_start |=> !ctrl_o.measure_start)
    else $error("measure start longer than one cycle");
  // shunt load only matters while tracking with surplus energy
  a_shunt_all: assert property ((!ctrl_o.harvester_on && plant_i.excess_energy) [*3] |->
    !storage_charging_indicator_n_o && !capacitor_charging_indicator_n_o && !power_tracking_indicator_n_o)
    else $error("indicators not all low as shunt");
  a_track_only: assert property ((!ctrl_o.harvester_on && !plant_i.excess_energy) [*3] |->
    storage_charging_indicator_n_o && capacitor_charging_indicator_n_o)
    else $error("wrong indicator while tracking");
  a_load_off_ind: assert property (ctrl_o.load_off [*3] |-> power_tracking_indicator_n_o)
    else $error("tracking indicator while load is off");
  // main scenarios reached
  c_track: cover property (ctrl_o.tracking_start);
  c_cal: cover property (ctrl_o.cal_capture);
  c_measure: cover property (ctrl_o.measure_start);
  c_load_off: cover property (ctrl_o.load_off [*3]);
endmodule
bind harvester_serial_command_port harvester_port_sva chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .meas_i(meas_i), .plant_i(plant_i), .calibrate_n_i(calibrate_n_i), .ctrl_o(ctrl_o),
  .cal_ref_o(cal_ref_o), .storage_charging_indicator_n_o(storage_charging_indicator_n_o),
  .capacitor_charging_indicator_n_o(capacitor_charging_indicator_n_o),
  .power_tracking_indicator_n_o(power_tracking_indicator_n_o));
`default_nettype wire

// file: test/host_uart_model.sv
// host_uart_model: host side of the 8N1 link, sends requests, collects replies
// assumes the same clock as the device; line idles high between frames
`timescale 1ns/1ns
`default_nettype none
module host_uart_model
  import harvester_pkg::*;
#(
  parameter int unsigned BIT_CYC_P = BIT_CYC
)
(
  // clock
  input wire logic clk_i,
  // serial pins, host view
  output logic txd_o,
  input wire logic rxd_i
);
  logic [7:0] rx_q[$];
  int frame_err = 0;
  initial txd_o = 1'b1;
  // ==========================================
  // one frame: start, eight bits lsb first, stop; idle high after
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_i);
      #1 txd_o = fr[i];
      repeat (BIT_CYC_P - 1) @(posedge clk_i);
    end
  endtask
  // whole request string, exact characters only
  task automatic send_req(input string s);
    foreach (s[i]) send_byte(s[i]);
  endtask
  // ==========================================
  // receiver samples mid-bit; a bad stop bit is counted
  always
  begin
    @(negedge rxd_i);
    repeat (BIT_CYC_P / 2) @(posedge clk_i);
    if (rxd_i === 1'b0)
    begin
      logic [7:0] b;
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYC_P) @(posedge clk_i);
        b[i] = rxd_i;
      end
      repeat (BIT_CYC_P) @(posedge clk_i);
      if (rxd_i !== 1'b1) frame_err++;
      rx_q.push_back(b);
    end
  end
endmodule
`default_nettype wire

// file: test/harvester_serial_command_port_test.sv
// harvester_serial_command_port_test: random readings, host requests, reply checks
// assumes the host model drives the link; long counts shortened by parameters
`timescale 1ns/1ns
`default_nettype none
module harvester_serial_command_port_test;
  import harvester_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rxd;
  logic txd;
  meas_t meas = '0;
  plant_t plant = '0;
  logic [1:0] mode_sel = 2'h0;
  logic calibrate_n = 1'b1;
  ctrl_t ctrl;
  logic [13:0] cal_ref;
  logic ind_store_n;
  logic ind_cap_n;
  logic ind_track_n;
  logic [31:0] lfsr_q = 32'h0000_d4d9;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // short bit period keeps the run inside the cycle budget
  localparam int unsigned BIT_T = 16;
  always #25 clk_i = ~clk_i;
  harvester_serial_command_port #(.MEASURE_CYC(100), .BLINK_PERIOD_CYC(40), .BLINK_LOW_CYC(8),
    .BIT_CYC_P(BIT_T)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .rxd_i(rxd), .txd_o(txd), .meas_i(meas), .mode_sel_i(mode_sel),
    .plant_i(plant), .calibrate_n_i(calibrate_n), .ctrl_o(ctrl), .cal_ref_o(cal_ref),
    .storage_charging_indicator_n_o(ind_store_n), .capacitor_charging_indicator_n_o(ind_cap_n),
    .power_tracking_indicator_n_o(ind_track_n));
  host_uart_model #(.BIT_CYC_P(BIT_T)) host (.clk_i(clk_i), .txd_o(rxd), .rxd_i(txd));
  // ==========================================
  // helpers and expectations
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int xdcr(input logic [1:0] m);
    int map[4] = '{4, 1, 3, 2};
    return map[m];
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // new readings kept inside the field widths
  task automatic new_meas();
    lfsr_q = lfsr(lfsr_q);
    meas.power_uw = 17'(lfsr_q % 100000);
    lfsr_q = lfsr(lfsr_q);
    meas.charge_pct = 7'(lfsr_q % 101);
    meas.vout_adc = 14'(lfsr_q[31:8] % 10000);
  endtask
  task automatic check_vec(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic check_str(input string nm, input string e, input string g);
    cmp_count++;
    if (g != e)
    begin
      fail_count++;
      $display("[ERR] %s expected %s seen %s", nm, e, g);
    end
  endtask
  // full request, then wait for the whole reply before going on
  task automatic do_cmd(input int c, input string fld);
    string e;
    string g;
    int n;
    e = $sformatf("@%0d,%s\r\n0", c, fld);
    host.rx_q.delete();
    host.send_req($sformatf("# %0d\r", c));
    n = 0;
    while (host.rx_q.size() < e.len() && n < 8000)
    begin
      @(posedge clk_i);
      n++;
    end
    g = "";
    foreach (host.rx_q[i]) g = {g, string'(host.rx_q[i])};
    check_str($sformatf("reply %0d", c), e, g);
    step(1);
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================
  // hang guard, about three times the cycles the whole sequence needs
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fail_count++;
      $display("[ERR] timeout expected reply seen none");
      results();
    end
  end
  // ==========================================
  // main sequence, walking the power states
  initial
  begin
    step(3);
    rst_n_i = 1'b1;
    step(5);
    plant.excess_energy = 1'b1;
    step(20);
    plant.excess_energy = 1'b0;
    do_cmd(8, "99"); // link test
    do_cmd(2, "01"); // tracking after start
    lfsr_q = lfsr(lfsr_q);
    mode_sel = lfsr_q[1:0];
    do_cmd(3, $sformatf("%02d", xdcr(mode_sel))); // strap code
    plant.tracking_done = 1'b1;
    step(4);
    check_vec("load_off", 32'h1, {31'h0, ctrl.load_off}); // cap held off load
    do_cmd(2, "02");
    plant.cap_charged = 1'b1;
    plant.in_regulation = 1'b1;
    new_meas();
    mode_sel = lfsr_q[3:2];
    step(4);
    do_cmd(7, $sformatf("%05d04%02d%03d", meas.power_uw, xdcr(mode_sel), meas.charge_pct));
    do_cmd(5, $sformatf("%03d", meas.charge_pct)); // asked twice
    do_cmd(5, $sformatf("%03d", meas.charge_pct));
    do_cmd(1, $sformatf("%05d", meas.power_uw));
    do_cmd(6, $sformatf("%04d", meas.vout_adc));
    check_vec("cal_ref", {18'h0, meas.vout_adc}, {18'h0, cal_ref});
    plant.in_regulation = 1'b0;
    step(4);
    do_cmd(2, "03"); // no input change, no tracking
    plant.output_off = 1'b1;
    step(4);
    do_cmd(2, "05");
    plant.output_off = 1'b0;
    plant.in_regulation = 1'b1;
    step(4);
    do_cmd(4, $sformatf("%c", 8'h06));
    do_cmd(9, $sformatf("%c", 8'h06)); // no power read follows
    // bad requests: digit zero, then a missing space
    host.rx_q.delete();
    host.send_req("# 0\r");
    host.send_req("#8\r");
    step(12 * BIT_T);
    check_vec("silent replies", 32'h0, host.rx_q.size());
    do_cmd(8, "99"); // parser back in step
    new_meas();
    step(2);
    calibrate_n = 1'b0;
    step(2);
    calibrate_n = 1'b1;
    step(4);
    check_vec("cal_ref pin", {18'h0, meas.vout_adc}, {18'h0, cal_ref});
    check_vec("frame errors", 32'h0, host.frame_err);
    results();
  end
endmodule
`default_nettype wire
